/* File: rtl/uosf_defs.svh */
// register offsets, field positions, reset values and timing counts for the usb status/error flag block
// assumes a 32-bit classic wishbone slave with word-aligned registers
`ifndef UOSF_DEFS_SVH
`define UOSF_DEFS_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define UOSF_OFS_HOST_CTRL   8'h00
`define UOSF_OFS_CFG2        8'h04
`define UOSF_OFS_OTG_FLAGS   8'h08
`define UOSF_OFS_ERR_FLAGS   8'h0C
`define UOSF_OFS_MODE        8'h10

// ****************************************************************
// field positions
// ****************************************************************
`define UOSF_CFG2_XCVR_OFF   0
`define UOSF_CFG2_CMP_OFF    1
`define UOSF_CFG2_BOOST_OFF  2
`define UOSF_CFG2_EXT_I2C    3
`define UOSF_CFG2_PULLUP     4
`define UOSF_CFG2_MASK       16'h001F
`define UOSF_OTG_MASK        16'h00FD
`define UOSF_ERR_MASK        16'h00BF
`define UOSF_HCTL_RW_MASK    16'h003F
`define UOSF_HCTL_SE0        6
`define UOSF_HCTL_J          7

// ****************************************************************
// reset values
// ****************************************************************
`define UOSF_RST_CFG2        16'h0000
`define UOSF_RST_FLAGS       16'h0000

// ****************************************************************
// timing: one millisecond at 250 MHz
// ****************************************************************
`define UOSF_CLK_MHZ         250
`define UOSF_MS_US           1000
`define UOSF_MS_CYCLES       (`UOSF_MS_US * `UOSF_CLK_MHZ)

`endif

/* File: rtl/uosf_pkg.sv */
// types shared by the usb status/error flag block
// assumes uosf_defs.svh is available on the include path
package uosf_pkg;

	// ****************************************************************
	// wishbone request carrier
	// ****************************************************************
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} uosf_wb_req_t;

	// ****************************************************************
	// raw link and packet event inputs
	// ****************************************************************
	typedef struct packed {
		logic id_pin;
		logic se0;
		logic j_state;
		logic dp_dm_act;
		logic a_sess_end;
		logic b_sess_end;
		logic a_vbus_vld;
	} uosf_line_t;

	typedef struct packed {
		logic stuff_err;
		logic overrun;
		logic turnaround_to;
		logic partial_byte;
		logic data_crc_fail;
		logic token_crc_fail;
		logic frame_end_err;
		logic pid_fail;
	} uosf_pkt_ev_t;

	// ****************************************************************
	// slave state machine
	// ****************************************************************
	typedef enum logic [1:0] {
		UOSF_IDLE = 2'b01,
		UOSF_ACK  = 2'b10
	} uosf_bus_st_t;

endpackage : uosf_pkg

/* File: rtl/uosf_w1c_flags.sv */
// sticky hardware-set flag bank with write-one-to-clear
// assumes clear strobes come from a write that enables the low byte lane, on the same clock
`timescale 1ns/1ps
module uosf_w1c_flags #(
	parameter int         WIDTH = 8
) (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic             ce_i,
	input  wire logic [WIDTH-1:0] set_i,
	input  wire logic [WIDTH-1:0] clr_i,
	output logic      [WIDTH-1:0] flags_o
);

	// ****************************************************************
	// one flag per bit
	// ****************************************************************
	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_flag
			logic flag_q;
			// set beats clear so an event never slips past a clearing write
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					flag_q <= 1'b0;
				end else if (ce_i) begin
					flag_q <= set_i[g] | (flag_q & ~clr_i[g]);
				end
			end
			assign flags_o[g] = flag_q;
		end
	endgenerate

endmodule : uosf_w1c_flags

/* File: rtl/uosf_status_flags.sv */
// usb otg status and error flag block with a classic wishbone slave
// assumes line and packet event inputs are levels/pulses; line inputs are asynchronous
`timescale 1ns/1ps
`include "uosf_defs.svh"
module uosf_status_flags
	import uosf_pkg::*;
#(
	parameter int unsigned MS_CYCLES = `UOSF_MS_CYCLES
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic         ce_i,
	input  wire logic         cyc_i,
	input  wire logic         stb_i,
	input  wire logic         we_i,
	input  wire logic [7:0]   adr_i,
	input  wire logic [3:0]   sel_i,
	input  wire logic [31:0]  dat_i,
	output logic      [31:0]  dat_o,
	output logic              ack_o,
	input  wire logic         module_power_on_i,
	input  wire logic         id_pin_i,
	input  wire logic         se0_i,
	input  wire logic         j_state_i,
	input  wire logic         dp_dm_act_i,
	input  wire logic         a_sess_end_i,
	input  wire logic         b_sess_end_i,
	input  wire logic         a_vbus_vld_i,
	input  wire logic         stuff_err_i,
	input  wire logic         overrun_i,
	input  wire logic         turnaround_to_i,
	input  wire logic         partial_byte_i,
	input  wire logic         data_crc_fail_i,
	input  wire logic         token_crc_fail_i,
	input  wire logic         frame_end_err_i,
	input  wire logic         pid_fail_i,
	input  wire logic [10:0]  rx_count_i,
	input  wire logic [10:0]  bd_count_i,
	output logic              rx_truncate_o,
	output logic              vbus_comparator_off_o,
	output logic              digital_status_en_o,
	output logic              boost_regulator_off_o,
	output logic              transceiver_off_o,
	output logic              ext_i2c_en_o,
	output logic              vbus_pullup_en_o,
	output logic              host_mode_o
);

	localparam int MSW = $clog2(MS_CYCLES + 1);

	// ****************************************************************
	// module state apart from the flag banks
	// ****************************************************************
	typedef struct packed {
		uosf_bus_st_t bus_st;
		logic [31:0]  rdata;
		logic [15:0]  cfg2;
		logic [5:0]   hctl;
		logic         host;
		uosf_line_t   sync1;
		uosf_line_t   sync2;
		uosf_line_t   prev;
		logic [MSW-1:0] ms_cnt;
		logic [MSW-1:0] ls_cnt;
		logic [1:0]   ls_stable;
		logic         trunc;
	} uosf_state_t;

	uosf_state_t s_q;
	uosf_state_t s_d;

	logic [7:0]  otg_set;
	logic [7:0]  err_set;
	logic [7:0]  otg_clr;
	logic [7:0]  err_clr;
	logic [7:0]  otg_flags;
	logic [7:0]  err_flags;
	logic        wr_hit;
	logic        rd_val;
	logic [15:0] rd_word;
	uosf_line_t  line_raw;
	uosf_line_t  ln;

	assign line_raw = '{id_pin: id_pin_i, se0: se0_i, j_state: j_state_i,
		dp_dm_act: dp_dm_act_i, a_sess_end: a_sess_end_i,
		b_sess_end: b_sess_end_i, a_vbus_vld: a_vbus_vld_i};
	assign ln = s_q.sync2;

	// ****************************************************************
	// flag banks
	// ****************************************************************
	uosf_w1c_flags #(
		.WIDTH   (8)
	) u_otg_flags (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.ce_i    (ce_i),
		.set_i   (otg_set),
		.clr_i   (otg_clr),
		.flags_o (otg_flags)
	);

	uosf_w1c_flags #(
		.WIDTH   (8)
	) u_err_flags (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.ce_i    (ce_i),
		.set_i   (err_set),
		.clr_i   (err_clr),
		.flags_o (err_flags)
	);

	// ****************************************************************
	// write strobe: a write is taken in the idle cycle, at the edge that raises ack
	// ****************************************************************
	assign wr_hit = cyc_i & stb_i & we_i & (s_q.bus_st == UOSF_IDLE) & sel_i[0];

	// clear only by a write that covers the flag byte
	always_comb begin
		otg_clr = 8'h00;
		err_clr = 8'h00;
		if (wr_hit && adr_i == `UOSF_OFS_OTG_FLAGS) begin
			otg_clr = dat_i[7:0] & 8'(`UOSF_OTG_MASK);
		end else if (wr_hit && adr_i == `UOSF_OFS_ERR_FLAGS) begin
			err_clr = dat_i[7:0] & 8'(`UOSF_ERR_MASK);
		end
	end

	// ****************************************************************
	// event detection
	// ****************************************************************
	always_comb begin
		otg_set = 8'h00;
		otg_set[7] = ln.id_pin ^ s_q.prev.id_pin;
		otg_set[6] = (s_q.ms_cnt == MSW'(MS_CYCLES - 1));
		otg_set[5] = (s_q.ls_cnt == MSW'(MS_CYCLES - 1))
			&& ({ln.se0, ln.j_state} != s_q.ls_stable);
		otg_set[4] = ln.dp_dm_act | (ln.a_vbus_vld ^ s_q.prev.a_vbus_vld);
		// xor catches both directions of each threshold crossing
		otg_set[3] = ln.a_sess_end ^ s_q.prev.a_sess_end;
		otg_set[2] = ln.b_sess_end ^ s_q.prev.b_sess_end;
		otg_set[0] = ln.a_vbus_vld ^ s_q.prev.a_vbus_vld;
		// otg flags only report while hosting
		otg_set = s_q.host ? otg_set : 8'h00;
		err_set = 8'h00;
		err_set[7] = stuff_err_i;
		err_set[5] = overrun_i | (rx_count_i > bd_count_i);
		err_set[4] = turnaround_to_i;
		err_set[3] = partial_byte_i;
		err_set[2] = data_crc_fail_i;
		// bit 1 changes meaning with the role
		err_set[1] = s_q.host ? frame_end_err_i : token_crc_fail_i;
		err_set[0] = pid_fail_i;
	end

	// ****************************************************************
	// read mux; unmapped reads answer zero
	// ****************************************************************
	always_comb begin
		rd_word = 16'h0000;
		if (adr_i == `UOSF_OFS_HOST_CTRL) begin
			rd_word = {8'h00, ln.j_state, ln.se0, s_q.hctl};
		end else if (adr_i == `UOSF_OFS_CFG2) begin
			rd_word = s_q.cfg2 & `UOSF_CFG2_MASK;
		end else if (adr_i == `UOSF_OFS_OTG_FLAGS) begin
			rd_word = {8'h00, otg_flags & 8'(`UOSF_OTG_MASK)};
		end else if (adr_i == `UOSF_OFS_ERR_FLAGS) begin
			rd_word = {8'h00, err_flags & 8'(`UOSF_ERR_MASK)};
		end else if (adr_i == `UOSF_OFS_MODE) begin
			rd_word = {15'h0000, s_q.host};
		end
	end
	assign rd_val = cyc_i & stb_i & ~we_i & (s_q.bus_st == UOSF_IDLE);

	// ****************************************************************
	// next-state logic
	// ****************************************************************
	always_comb begin
		s_d = s_q;
		s_d.sync1 = line_raw;
		s_d.sync2 = s_q.sync1;
		s_d.prev = ln;
		// free-running millisecond tick
		s_d.ms_cnt = (s_q.ms_cnt == MSW'(MS_CYCLES - 1)) ? '0 : s_q.ms_cnt + MSW'(1);
		// line state timer restarts on any change of se0/j
		if ({ln.se0, ln.j_state} != {s_q.prev.se0, s_q.prev.j_state}) begin
			s_d.ls_cnt = '0;
		end else if (s_q.ls_cnt == MSW'(MS_CYCLES - 1)) begin
			s_d.ls_cnt = s_q.ls_cnt;
			s_d.ls_stable = {ln.se0, ln.j_state};
		end else begin
			s_d.ls_cnt = s_q.ls_cnt + MSW'(1);
		end
		s_d.trunc = (rx_count_i >= bd_count_i);
		case (s_q.bus_st)
			UOSF_IDLE: begin
				if (cyc_i && stb_i) begin
					s_d.bus_st = UOSF_ACK;
					s_d.rdata = rd_val ? {16'h0000, rd_word} : 32'h0000_0000;
				end
			end
			UOSF_ACK: begin
				s_d.bus_st = UOSF_IDLE;
			end
			default: begin
				s_d.bus_st = UOSF_IDLE;
			end
		endcase
		// control writes; software keeps the disables steady while powered
		if (wr_hit && adr_i == `UOSF_OFS_CFG2) begin
			s_d.cfg2 = dat_i[15:0] & `UOSF_CFG2_MASK;
		end else if (wr_hit && adr_i == `UOSF_OFS_HOST_CTRL) begin
			s_d.hctl = dat_i[5:0];
		end else if (wr_hit && adr_i == `UOSF_OFS_MODE) begin
			s_d.host = dat_i[0];
		end
	end

	// ****************************************************************
	// state register
	// ****************************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_q <= '{bus_st: UOSF_IDLE, cfg2: `UOSF_RST_CFG2, default: '0};
		end else if (ce_i) begin
			s_q <= s_d;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	assign ack_o = (s_q.bus_st == UOSF_ACK);
	assign dat_o = s_q.rdata;
	assign rx_truncate_o = s_q.trunc;
	// comparator off hands status to the digital interface
	assign vbus_comparator_off_o = s_q.cfg2[`UOSF_CFG2_CMP_OFF];
	assign digital_status_en_o = s_q.cfg2[`UOSF_CFG2_CMP_OFF];
	assign boost_regulator_off_o = s_q.cfg2[`UOSF_CFG2_BOOST_OFF];
	assign transceiver_off_o = s_q.cfg2[`UOSF_CFG2_XCVR_OFF];
	assign ext_i2c_en_o = s_q.cfg2[`UOSF_CFG2_EXT_I2C];
	assign vbus_pullup_en_o = s_q.cfg2[`UOSF_CFG2_PULLUP];
	assign host_mode_o = s_q.host;

endmodule : uosf_status_flags

/* File: testbench/uosf_sva.sv */
// port-level assertions for the usb status and error flag block
// assumes ce_i is held high by the surroundings
`timescale 1ns/1ps
`include "uosf_defs.svh"
module uosf_sva (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic        we_i,
	input wire logic [7:0]  adr_i,
	input wire logic [3:0]  sel_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic        ack_o,
	input wire logic [10:0] rx_count_i,
	input wire logic [10:0] bd_count_i,
	input wire logic        rx_truncate_o,
	input wire logic        vbus_comparator_off_o,
	input wire logic        digital_status_en_o,
	input wire logic        boost_regulator_off_o,
	input wire logic        transceiver_off_o,
	input wire logic        host_mode_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic take, cfg_wr, mode_wr, rx_over;
	// byte count reached the descriptor size in this cycle
	assign rx_over = rx_count_i >= bd_count_i;
	// a request that the idle slave accepts at this edge
	assign take    = cyc_i && stb_i && !ack_o;
	assign cfg_wr  = take && we_i && sel_i[0] && adr_i == `UOSF_OFS_CFG2;
	assign mode_wr = take && we_i && sel_i[0] && adr_i == `UOSF_OFS_MODE;
	// ****************************************************************
	// properties
	// ****************************************************************
	property p_ack; take |=> ack_o ##1 !ack_o; endproperty
	a_ack: assert property (p_ack) else $error("ack missing or too long");
	property p_ack_src; ack_o |-> $past(take); endproperty
	a_ack_src: assert property (p_ack_src) else $error("ack without request");
	property p_cmp_pair; vbus_comparator_off_o == digital_status_en_o; endproperty
	a_cmp_pair: assert property (p_cmp_pair) else $error("status path split");
	property p_cfg_wr; cfg_wr |=> transceiver_off_o == $past(dat_i[0]) &&
		vbus_comparator_off_o == $past(dat_i[1]) && boost_regulator_off_o == $past(dat_i[2]) &&
		digital_status_en_o == $past(dat_i[1]);
	endproperty
	a_cfg_wr: assert property (p_cfg_wr) else $error("cfg write lost");
	property p_cfg_hold; !$past(cfg_wr) && !$past(rst_i) |->
		$stable({transceiver_off_o, vbus_comparator_off_o, boost_regulator_off_o});
	endproperty
	a_cfg_hold: assert property (p_cfg_hold) else $error("cfg moved by itself");
	property p_mode; mode_wr |=> host_mode_o == $past(dat_i[0]); endproperty
	a_mode: assert property (p_mode) else $error("mode write lost");
	property p_upper; ack_o && !we_i |-> dat_o[31:8] == 24'h000000; endproperty
	a_upper: assert property (p_upper) else $error("upper read bits set");
	property p_unmap; take && !we_i && adr_i > 8'h10 |=> dat_o == 32'h00000000; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
	property p_trunc; !$past(rst_i) |-> rx_truncate_o == $past(rx_over);
	endproperty
	a_trunc: assert property (p_trunc) else $error("truncate wrong");
endmodule : uosf_sva

bind uosf_status_flags uosf_sva u_sva (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
	.dat_i, .dat_o, .ack_o, .rx_count_i, .bd_count_i, .rx_truncate_o, .vbus_comparator_off_o,
	.digital_status_en_o, .boost_regulator_off_o, .transceiver_off_o, .host_mode_o);

/* File: testbench/uosf_peer.sv */
// far-side model: cable peer and vbus supply seen as line levels
// assumes the bench calls drive() from one thread, one change at a time
`timescale 1ns/1ps
module uosf_peer
	import uosf_pkg::*;
(
	input  wire logic clk_i,
	output uosf_line_t line_o
);
	initial line_o = '0;
	// a change launches just after an edge and then holds, like a settled cable
	task automatic drive(input uosf_line_t v);
		@(posedge clk_i);
		line_o <= v;
	endtask : drive
endmodule : uosf_peer

/* File: testbench/usb_otg_status_error_flags_test.sv */
// self-checking bench for the usb status and error flag block
// assumes a short millisecond count; reads are scored by a separate monitor
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((e) !== (g)) begin n_mismatch++; \
	$display("Error %s expected %h seen %h", nm, e, g); end end
module usb_otg_status_error_flags_test import uosf_pkg::*; ;
	localparam int MS = 20;
	logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, pwr = 1'b0;
	logic [7:0] adr_i = 8'h00;
	logic [31:0] dat_i = 32'h0, dat_o, v, mk, xe;
	logic [3:0] sel = 4'hF;
	logic ack_o, trc, cmp, dse, bst, xcv, i2c, pu, hst;
	logic [10:0] rx_count_i = 11'h000, bd_count_i = 11'h010;
	uosf_pkt_ev_t pkt = '0;
	uosf_line_t ln;
	int seed = 32'h986c72ca, n_mismatch = 0, num_checks = 0;
	logic [31:0] q_e[$], q_m[$];
	logic [6:0] lm[5] = '{7'h40, 7'h04, 7'h02, 7'h01, 7'h08};
	logic [31:0] fb[5] = '{32'h80, 32'h08, 32'h04, 32'h01, 32'h10};
	always #2 clk_i = ~clk_i;
	uosf_peer peer (.clk_i, .line_o(ln));
	uosf_status_flags #(.MS_CYCLES(MS)) DUT (.clk_i, .rst_i, .ce_i(1'b1), .cyc_i, .stb_i,
		.we_i, .adr_i, .sel_i(sel), .dat_i, .dat_o, .ack_o, .module_power_on_i(pwr),
		.id_pin_i(ln.id_pin), .se0_i(ln.se0), .j_state_i(ln.j_state),
		.dp_dm_act_i(ln.dp_dm_act), .a_sess_end_i(ln.a_sess_end),
		.b_sess_end_i(ln.b_sess_end), .a_vbus_vld_i(ln.a_vbus_vld),
		.stuff_err_i(pkt.stuff_err), .overrun_i(pkt.overrun),
		.turnaround_to_i(pkt.turnaround_to), .partial_byte_i(pkt.partial_byte),
		.data_crc_fail_i(pkt.data_crc_fail), .token_crc_fail_i(pkt.token_crc_fail),
		.frame_end_err_i(pkt.frame_end_err), .pid_fail_i(pkt.pid_fail), .rx_count_i,
		.bd_count_i, .rx_truncate_o(trc), .vbus_comparator_off_o(cmp),
		.digital_status_en_o(dse), .boost_regulator_off_o(bst), .transceiver_off_o(xcv),
		.ext_i2c_en_o(i2c), .vbus_pullup_en_o(pu), .host_mode_o(hst));
	task automatic stop_test();
		// a read that was never answered is a lost result
		if (q_e.size() != 0) n_mismatch++;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : stop_test
	// one classic cycle; p pulses packet events at the edge that takes it
	task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d,
		input uosf_pkt_ev_t p = '0);
		int k;
		@(posedge clk_i);
		{cyc_i, stb_i, we_i, adr_i, dat_i, pkt} <= {2'b11, w, a, 16'h0000, d, p};
		for (k = 0; k < 20; k++) begin
			@(posedge clk_i);
			pkt <= '0;
			if (ack_o === 1'b1) break;
		end
		if (k == 20) begin
			n_mismatch++;
			stop_test();
		end
		{cyc_i, stb_i} <= 2'b00;
	endtask : wb
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
		q_e.push_back(e);
		q_m.push_back(m);
		wb(1'b0, a, 16'h0000);
	endtask : rd
	function automatic logic [31:0] err_bit(input int i, input int h);
		logic [7:0] t[8];
		t = '{8'h01, 8'h02, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h80};
		if ((i == 1 && h == 0) || (i == 2 && h == 1)) return 32'h0;
		return {24'h000000, t[i]};
	endfunction : err_bit
	// result side: every read ack retires the oldest note, masked to what it cares about
	always @(posedge clk_i) begin
		if (ack_o === 1'b1 && we_i === 1'b0 && q_e.size() > 0) begin
			mk = q_m.pop_front();
			xe = q_e.pop_front();
			`CHK("read data", xe, dat_o & mk)
		end
	end
	// ****************************************************************
	// scenarios
	// ****************************************************************
	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int a = 0; a <= 20; a += 4) rd(a[7:0], 32'h0);
		wb(1'b1, 8'h14, 16'hFFFF);
		rd(8'h14, 32'h0);
		$display("done reset and unmapped");
		// config is changed only while the module power is off
		for (int i = 0; i < 2; i++) begin
			v = i ? ~v : $random(seed);
			wb(1'b1, 8'h04, v[15:0]);
			rd(8'h04, v & 32'h1F);
			`CHK("cfg outputs", v[4:0], {pu, i2c, bst, cmp, xcv})
			`CHK("status path", v[1], dse)
		end
		// a write without the low byte lane must leave the config alone
		sel <= 4'hE;
		wb(1'b1, 8'h04, ~v[15:0]);
		sel <= 4'hF;
		rd(8'h04, v & 32'h1F);
		pwr <= 1'b1;
		$display("done config");
		for (int m = 0; m < 2; m++) begin
			wb(1'b1, 8'h10, m[15:0]);
			`CHK("host mode", m[0], hst)
			for (int i = 0; i < 8; i++) begin
				wb(1'b1, 8'h14, 16'h0000, 8'h01 << i);
				rd(8'h0C, err_bit(i, m));
				wb(1'b1, 8'h0C, 16'hFFFF);
			end
		end
		wb(1'b1, 8'h14, 16'h0000, 8'h81);
		wb(1'b1, 8'h0C, 16'h0001);
		rd(8'h0C, 32'h80);
		wb(1'b1, 8'h0C, 16'h00FF, 8'h01);
		rd(8'h0C, 32'h01);
		v = $random(seed);
		// top bit kept clear so the larger count cannot wrap
		bd_count_i <= {1'b0, v[9:0]};
		rx_count_i <= {1'b0, v[9:0]} + 11'h001;
		repeat (3) @(posedge clk_i);
		`CHK("truncate", 1'b1, trc)
		rd(8'h0C, 32'h20, 32'h20);
		rx_count_i <= 11'h000;
		$display("done error flags");
		// otg flags in host mode: id, session, vbus and activity lines each rise, then fall
		for (int k = 0; k < 10; k++) begin
			wb(1'b1, 8'h08, 16'h00FF);
			peer.drive(ln ^ lm[k/2]);
			repeat (6) @(posedge clk_i);
			rd(8'h08, fb[k/2], fb[k/2]);
		end
		for (int k = 0; k < 2; k++) begin
			wb(1'b1, 8'h08, 16'h00FF);
			if (k == 0) peer.drive(ln ^ 7'h20);
			repeat (MS + 10) @(posedge clk_i);
			rd(8'h08, k ? 32'h40 : 32'h60, 32'h60);
		end
		rd(8'h00, 32'h40, 32'hC0);
		wb(1'b1, 8'h10, 16'h0000);
		wb(1'b1, 8'h08, 16'h00FF);
		peer.drive(ln ^ 7'h40);
		repeat (MS + 10) @(posedge clk_i);
		rd(8'h08, 32'h0);
		$display("done otg flags");
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(8'h04, 32'h0);
		rd(8'h0C, 32'h0);
		$display("done second reset");
		// let the monitor retire the last read before the verdict
		repeat (2) @(posedge clk_i);
		stop_test();
	end
endmodule : usb_otg_status_error_flags_test
